// ---- verilog/pdt_consts.svh ----
`ifndef PDT_CONSTS_SVH
`define PDT_CONSTS_SVH

// clock, time base, counter and output constants
`define PDT_CLK_MHZ          100
`define PDT_TB_MAX_KHZ       200
`define PDT_TB_MIN_CYC       ((`PDT_CLK_MHZ * 1000 + `PDT_TB_MAX_KHZ - 1) / `PDT_TB_MAX_KHZ)
`define PDT_TB_DEF_PERIOD    500
`define PDT_HARM_MAX         10
`define PDT_CNT_W            8
`define PDT_CNT_RESET        8'h00
`define PDT_OUT_RELEASED     8'hff

`endif

// ---- verilog/pdt_pkg.sv ----
package pdt_pkg;
    typedef enum logic [0:0] {
        PDT_IDLE,
        PDT_RUN
    } pdt_state_t;
endpackage

// ---- verilog/pdt_timer.sv ----
`timescale 1ns/100ps
`include "pdt_consts.svh"

// Notes on behaviour
// - trigger rising edge starts a timing cycle
// - trigger starts time base, counter, outputs low
// - eight-bit counter counts time-base pulses
// - reset rising edge ends the cycle
// - idle: time base, counter off, outputs released
// - outputs wired to reset give one-shot
// - no feedback means free counting forever
// - outputs open-drain: pull low or release
// - wired bus low while any output low
// - outputs weigh one, two, four... periods
// - cycle length selectable one to 255 periods
// - after power-up settle into reset state
// - running cycle ignores further triggers
// - simultaneous trigger and reset: trigger wins
// - time base aligns to sync harmonics
// - divider output pulses one clock, every N clocks
// - no sync means free-running time base
// - time base need not exceed 200 kHz
// - external clock advances on falling edge
module pdt_timer #(
    parameter int CNT_W     = `PDT_CNT_W,
    parameter int PER_W     = 24,
    parameter int TB_MIN    = `PDT_TB_MIN_CYC
) (
    input  wire logic             clock_i,
    input  wire logic             resetn_i,
    input  wire logic             trigger_i,
    input  wire logic             reset_i,
    input  wire logic             sync_i,
    input  wire logic             ext_clk_sel_i,
    input  wire logic             ext_clk_i,
    input  wire logic [PER_W-1:0] tb_period_i,
    output logic      [CNT_W-1:0] cnt_out_o,
    output logic      [CNT_W-1:0] cnt_oe_o,
    output logic                  running_o,
    output logic                  tb_tick_o
);

    logic                 rst_meta_r;
    logic                 rst_sync_r;
    logic                 trig_d_r;
    logic                 trig_d_nxt;
    logic                 rst_d_r;
    logic                 rst_d_nxt;
    logic                 sync_d_r;
    logic                 sync_d_nxt;
    logic                 ext_d_r;
    logic                 ext_d_nxt;
    pdt_pkg::pdt_state_t  state_r;
    pdt_pkg::pdt_state_t  state_nxt;
    logic [CNT_W-1:0]     cnt_r;
    logic [CNT_W-1:0]     cnt_nxt;
    logic [PER_W-1:0]     tb_cnt_r;
    logic [PER_W-1:0]     tb_cnt_nxt;
    logic [PER_W-1:0]     period_eff;
    logic [CNT_W-1:0]     oe_nxt;
    logic                 tick;
    logic                 trig_rise;
    logic                 rst_rise;
    logic                 sync_rise;
    logic                 ext_fall;

    // state decode shared by time base, enables and run flag
    function automatic logic run_sel(input pdt_pkg::pdt_state_t st);
        run_sel = (st == pdt_pkg::PDT_RUN);
    endfunction

    // reset release through two flops
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // edge detection of control inputs
    always_comb begin
        trig_d_nxt = trigger_i;
        rst_d_nxt  = reset_i;
        sync_d_nxt = sync_i;
        ext_d_nxt  = ext_clk_i;
    end

    always_ff @(posedge clock_i or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            trig_d_r <= 1'b0;
            rst_d_r  <= 1'b0;
            sync_d_r <= 1'b0;
            ext_d_r  <= 1'b0;
        end else begin
            trig_d_r <= trig_d_nxt;
            rst_d_r  <= rst_d_nxt;
            sync_d_r <= sync_d_nxt;
            ext_d_r  <= ext_d_nxt;
        end
    end

    assign trig_rise = trigger_i & ~trig_d_r;
    assign rst_rise  = reset_i & ~rst_d_r;
    assign sync_rise = sync_i & ~sync_d_r;
    assign ext_fall  = ~ext_clk_i & ext_d_r;

    // clamp period so time base stays at or under its top rate
    assign period_eff = (tb_period_i < PER_W'(TB_MIN)) ? PER_W'(TB_MIN)
                                                       : tb_period_i;

    // time base: clock-enable pulse, one per programmed period
    always_comb begin
        tb_cnt_nxt = tb_cnt_r;
        tick       = 1'b0;
        if (!run_sel(state_r)) begin
            tb_cnt_nxt = '0;
        end else if (ext_clk_sel_i) begin
            tb_cnt_nxt = '0;
            tick       = ext_fall;
        end else if (sync_rise) begin
            tb_cnt_nxt = '0;
            tick       = (tb_cnt_r != '0);
        end else if (tb_cnt_r >= period_eff - PER_W'(1)) begin
            tb_cnt_nxt = '0;
            tick       = 1'b1;
        end else begin
            tb_cnt_nxt = tb_cnt_r + PER_W'(1);
        end
    end

    // control state and counter
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            pdt_pkg::PDT_IDLE: begin
                if (trig_rise) begin
                    state_nxt = pdt_pkg::PDT_RUN;
                    cnt_nxt   = `PDT_CNT_RESET;
                end
            end
            pdt_pkg::PDT_RUN: begin
                if (rst_rise) begin
                    state_nxt = pdt_pkg::PDT_IDLE;
                    cnt_nxt   = `PDT_CNT_RESET;
                end else if (tick) begin
                    cnt_nxt = cnt_r + CNT_W'(1);
                end
                // trigger with reset while running: trigger wins, count holds
                cnt_nxt = trig_rise && rst_rise ? cnt_r : cnt_nxt;
                if (trig_rise && rst_rise) begin
                    state_nxt = pdt_pkg::PDT_RUN;
                end
            end
            default: begin
                state_nxt = pdt_pkg::PDT_IDLE;
                cnt_nxt   = `PDT_CNT_RESET;
            end
        endcase
    end

    // idle trigger with reset: trigger still wins since idle ignores reset
    // per-bit enable: pull while running and counter bit is zero
    generate
        for (genvar b = 0; b < CNT_W; b++) begin : g_oe
            assign oe_nxt[b] = run_sel(state_nxt) & ~cnt_nxt[b];
        end
    endgenerate

    always_ff @(posedge clock_i or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            state_r   <= pdt_pkg::PDT_IDLE;
            cnt_r     <= `PDT_CNT_RESET;
            tb_cnt_r  <= '0;
            cnt_oe_o  <= '0;
            running_o <= 1'b0;
            tb_tick_o <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            cnt_r     <= cnt_nxt;
            tb_cnt_r  <= tb_cnt_nxt;
            cnt_oe_o  <= oe_nxt;
            running_o <= run_sel(state_nxt);
            tb_tick_o <= tick;
        end
    end

    // open-drain data is always low; only the enable moves
    always_ff @(posedge clock_i or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            cnt_out_o <= '0;
        end else begin
            cnt_out_o <= '0;
        end
    end

endmodule

// ---- sim/pdt_bus_model.sv ----
`timescale 1ns/100ps
module pdt_bus_model (
    input  wire logic       clock_i,
    input  wire logic [7:0] oe_i,
    input  wire logic [7:0] mask_i,
    input  wire logic       fb_en_i,
    input  wire logic       man_rst_i,
    output logic            rst_o
);
    logic bus_r;
    // pulled-up bus, low while any selected output pulls
    always_ff @(posedge clock_i) bus_r <= ~|(oe_i & mask_i);
    // delayed feedback to reset; manual reset when feedback off
    assign rst_o = fb_en_i ? bus_r : man_rst_i;
endmodule

// ---- sim/pdt_timer_properties.sv ----
`timescale 1ns/100ps
module pdt_timer_chk #(parameter int CNT_W = 8) (
    input wire logic             clock_i,
    input wire logic             resetn_i,
    input wire logic             trigger_i,
    input wire logic             reset_i,
    input wire logic [CNT_W-1:0] cnt_out_o,
    input wire logic [CNT_W-1:0] cnt_oe_o,
    input wire logic             running_o,
    input wire logic             tb_tick_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    idle_release_a: assert property (!running_o |-> cnt_oe_o == '0)
        else $error("pulled while idle");
    data_low_a: assert property (cnt_out_o == '0) else $error("data not low");
    trig_start_a: assert property ($rose(trigger_i) && !running_o
        |=> running_o && &cnt_oe_o) else $error("no start");
    trig_ignore_a: assert property (running_o && $rose(trigger_i) && !$rose(reset_i)
        |=> running_o) else $error("retrigger acted");
    trig_wins_a: assert property (running_o && $rose(trigger_i) && $rose(reset_i)
        |=> running_o) else $error("reset beat trigger");
    reset_end_a: assert property (running_o && $rose(reset_i) && !$rose(trigger_i)
        |=> !running_o && cnt_oe_o == '0) else $error("no stop");
    count_step_a: assert property (
        running_o && $past(running_o) && $changed(cnt_oe_o)
        |-> ~cnt_oe_o == CNT_W'(~$past(cnt_oe_o) + 1'b1)) else $error("bad step");
    tick_pulse_a: assert property (tb_tick_o |=> !tb_tick_o) else $error("long tick");
    run_end_c: cover property (running_o && $rose(reset_i));
    tick_c: cover property (tb_tick_o && running_o);
    wrap_c: cover property (running_o && $past(cnt_oe_o) == '0 && &cnt_oe_o);
endmodule

bind pdt_timer pdt_timer_chk #(.CNT_W(CNT_W)) chk_u (.clock_i(clock_i), .resetn_i(resetn_i),
    .trigger_i(trigger_i), .reset_i(reset_i), .cnt_out_o(cnt_out_o), .cnt_oe_o(cnt_oe_o),
    .running_o(running_o), .tb_tick_o(tb_tick_o));

// ---- sim/programmable_delay_timer_tb.sv ----
`timescale 1ns/100ps
module programmable_delay_timer_tb;
    logic       clock_i = 0, resetn_i = 0, trig = 0, mrst = 0, fb_en = 1, rst, run, tick;
    logic       sync = 0, esel = 0, eclk = 0;
    logic [7:0] mask = 8'h01, oe;
    int         n_mismatch = 0, checks_done = 0, dur = 0;
    int         exp_q[$];
    always #5 clock_i = ~clock_i;
    pdt_timer #(.TB_MIN(4)) dut_u (.clock_i(clock_i), .resetn_i(resetn_i), .trigger_i(trig),
        .reset_i(rst), .sync_i(sync), .ext_clk_sel_i(esel), .ext_clk_i(eclk),
        .tb_period_i(24'h00_0010), .cnt_out_o(), .cnt_oe_o(oe), .running_o(run),
        .tb_tick_o(tick));
    pdt_bus_model bus_u (.clock_i(clock_i), .oe_i(oe), .mask_i(mask), .fb_en_i(fb_en),
        .man_rst_i(mrst), .rst_o(rst));
    task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // run length in periods of 16 cycles against the queued count
    always @(posedge clock_i) begin
        if (run === 1'b1) dur <= dur + 1;
        else if (dur > 0) begin
            if (exp_q.size() > 0) chk("run_len", 9'(dur / 16), 9'(exp_q.pop_front()));
            dur <= 0;
        end
    end
    task automatic pulse(input logic r);
        trig = 1;
        mrst = r;
        @(negedge clock_i);
        trig = 0;
        mrst = 0;
    endtask
    initial begin
        int i;
        void'($urandom(32'hd61a));
        repeat (8) @(negedge clock_i);
        resetn_i = 1;
        repeat (4) @(negedge clock_i);
        chk("idle", {run, oe}, 9'h000);
        for (i = 0; i < 8; i++) begin
            mask = (i == 0) ? 8'h01 : (i == 1) ? 8'hff : 8'($urandom_range(255, 1));
            exp_q.push_back(int'(mask));
            pulse(1'b0);
            chk("start", {run, oe}, 9'h1ff);
            repeat (10) @(negedge clock_i);
            pulse(1'b0);
            for (int k = 0; k < 5000 && run !== 1'b0; k++) @(negedge clock_i);
            if (run !== 1'b0) begin
                n_mismatch++;
                print_verdict();
            end
            $display("one-shot test %0d done", i);
        end
        fb_en = 0;
        pulse(1'b0);
        repeat (4200) @(negedge clock_i);
        chk("free_run", {8'h00, run}, 9'h001);
        pulse(1'b1);
        chk("trig_wins", {8'h00, run}, 9'h001);
        @(negedge clock_i);
        mrst = 1;
        @(negedge clock_i);
        chk("reset_end", {run, oe}, 9'h000);
        $display("free-run test done");
        mrst = 0;
        esel = 1;
        pulse(1'b0);
        for (i = 1; i < 4; i++) begin
            eclk = 1;
            repeat (2) @(negedge clock_i);
            eclk = 0;
            repeat (2) @(negedge clock_i);
            chk("ext_step", {run, oe}, {1'b1, ~8'(i)});
        end
        esel = 0;
        mrst = 1;
        @(negedge clock_i);
        pulse(1'b0);
        repeat (5) @(negedge clock_i);
        sync = 1;
        @(negedge clock_i);
        sync = 0;
        chk("sync_tick", {tick, oe}, 9'h1fe);
        mrst = 1;
        @(negedge clock_i);
        chk("sync_end", {run, oe}, 9'h000);
        $display("external clock and sync tests done");
        print_verdict();
    end
endmodule
